/* hdl/adc_seq_pkg.sv */
package adc_seq_pkg;

  localparam int NUM_SEQ     = 4;
  localparam int RESULT_W    = 10;
  localparam int WORD_W      = 32;
  localparam int ADDR_W      = 12;
  localparam int NUM_EXT_TRG = 4;
  localparam int ACC_W       = 16;

  // Register offsets (byte addresses)
  localparam logic [11:0] OFF_ACTIVE     = 12'h000;
  localparam logic [11:0] OFF_RAW_IRQ    = 12'h004;
  localparam logic [11:0] OFF_IRQ_MASK   = 12'h008;
  localparam logic [11:0] OFF_IRQ_CLEAR  = 12'h00C;
  localparam logic [11:0] OFF_OVERFLOW   = 12'h010;
  localparam logic [11:0] OFF_EVENT_SEL  = 12'h014;
  localparam logic [11:0] OFF_UNDERFLOW  = 12'h018;
  localparam logic [11:0] OFF_PRIORITY   = 12'h020;
  localparam logic [11:0] OFF_INITIATE   = 12'h028;
  localparam logic [11:0] OFF_AVERAGE    = 12'h030;
  localparam logic [11:0] OFF_SEQ_BASE   = 12'h040;
  localparam logic [11:0] SEQ_STRIDE     = 12'h020;
  localparam logic [11:0] SEQ_INPUT_SEL  = 12'h000;
  localparam logic [11:0] SEQ_SAMPLE_CTL = 12'h004;
  localparam logic [11:0] SEQ_RESULT     = 12'h008;
  localparam logic [11:0] SEQ_STATUS     = 12'h00C;

  // Reset values and averaging limit
  localparam logic [15:0] PRIORITY_RESET = 16'h3210;
  localparam logic [2:0]  AVERAGE_RESET  = 3'h0;
  localparam logic [2:0]  AVERAGE_MAX    = 3'h6;

  // Sample-control nibble fields
  localparam int CTL_DIFF = 0;
  localparam int CTL_END  = 1;
  localparam int CTL_IE   = 2;
  localparam int CTL_TEMP = 3;

  // FIFO status fields
  localparam int STAT_TAIL_LSB = 0;
  localparam int STAT_HEAD_LSB = 4;
  localparam int STAT_EMPTY    = 8;
  localparam int STAT_FULL     = 12;

  // Converter clock divider
  localparam int SYS_CLK_KHZ     = 25000;
  localparam int CONV_TARGET_KHZ = 16667;
  localparam int CONV_DIV        = (SYS_CLK_KHZ + CONV_TARGET_KHZ - 1) / CONV_TARGET_KHZ;

  typedef enum logic [3:0] {
    EV_SOFTWARE = 4'h0,
    EV_TIMER    = 4'h1,
    EV_COMPARE  = 4'h2,
    EV_PWM      = 4'h3,
    EV_GPIO     = 4'h4,
    EV_ALWAYS   = 4'hF
  } event_src_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_CONV    = 3'b010,
    ST_RELEASE = 3'b100
  } seq_state_t;

  function automatic int seqDepth(input int n);
    seqDepth = (n == 0) ? 8 : (n == 3) ? 1 : 4;
  endfunction : seqDepth

  function automatic logic [31:0] seqNibbleMask(input int n);
    seqNibbleMask = 32'hFFFF_FFFF >> (32 - 4 * seqDepth(n));
  endfunction : seqNibbleMask

endpackage : adc_seq_pkg

/* hdl/seq_result_fifo.sv */
`timescale 1ns/1ps
module seq_result_fifo #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 10
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             pushValid,
  input  wire logic [WIDTH-1:0] pushData,
  input  wire logic             popReq,
  output logic      [WIDTH-1:0] popData,
  output logic      [3:0]       headPtr,
  output logic      [3:0]       tailPtr,
  output logic                  full,
  output logic                  empty
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    head;
  logic [PW-1:0]    tail;
  logic [PW:0]      count;

  assign full    = (count == (PW+1)'(DEPTH));
  assign empty   = (count == '0);
  assign popData = mem[head];
  assign headPtr = 4'(head);
  assign tailPtr = 4'(tail);

  // Circular storage: writes past full and reads of empty leave pointers alone
  always_ff @(posedge clk_sys) begin
    if (pushValid && !full) begin
      mem[tail] <= pushData;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      head  <= '0;
      tail  <= '0;
      count <= '0;
    end else begin
      if (pushValid && !full) begin
        tail <= (tail == LAST) ? '0 : tail + 1'b1;
      end
      if (popReq && !empty) begin
        head <= (head == LAST) ? '0 : head + 1'b1;
      end
      count <= count + (PW+1)'(pushValid && !full) - (PW+1)'(popReq && !empty);
    end
  end

endmodule : seq_result_fifo

/* hdl/adc_sample_sequencer_control.sv */
`timescale 1ns/1ps
// What this block does
// - 10-bit results, four inputs plus temperature sensor
// - Four independent sequencers, each with own FIFO
// - FIFO word is 32 bits, result low
// - Capacities 8, 4, 4, 1 samples and depths
// - Each step: input nibble plus control nibble
// - Control nibble: temperature, irq enable, end, differential
// - Run only when enabled; configure while disabled
// - Same input may repeat within a sequence
// - Interrupt after each sample with enable set
// - Stop after the step marked end
// - Circular FIFO; each read pops oldest entry
// - Status shows head, tail, full, empty
// - Overflow and underflow recorded per sequencer
// - Converter side runs in its own clock
// - Converter clock divider set automatically by hardware
// - Averaging of up to 64 conversions
// - Per-sequencer trigger source, interrupt and priority
// - Steps convert back to back once triggered
// - Interrupt equals raw status and mask; W1C
// - Concurrent triggers served by priority, 0 highest
// - Averaging off after reset; one shared setting
// - Initiate bit starts software-triggered sequencer
module adc_sample_sequencer_control
(
  input  wire logic                                clk_sys,
  input  wire logic                                reset_n,
  input  wire logic [adc_seq_pkg::ADDR_W-1:0]      regAddr,
  input  wire logic [adc_seq_pkg::WORD_W-1:0]      regWdata,
  input  wire logic                                regWrite,
  input  wire logic                                regRead,
  output logic      [adc_seq_pkg::WORD_W-1:0]      regRdata,
  input  wire logic [adc_seq_pkg::NUM_EXT_TRG-1:0] extTrigger,
  output logic                                     convClk,
  output logic                                     convStart,
  output logic      [3:0]                          convInput,
  output logic                                     convDiff,
  output logic                                     convTempSel,
  input  wire logic                                convDone,
  input  wire logic [adc_seq_pkg::RESULT_W-1:0]    convResult,
  output logic      [adc_seq_pkg::NUM_SEQ-1:0]     seqIrq
);
  import adc_seq_pkg::*;

  logic [NUM_SEQ-1:0]  activeEnable;
  logic [NUM_SEQ-1:0]  rawIrq;
  logic [NUM_SEQ-1:0]  irqMask;
  logic [NUM_SEQ-1:0]  overflowFlag;
  logic [NUM_SEQ-1:0]  underflowFlag;
  logic [NUM_SEQ-1:0]  pending;
  logic [15:0]         eventSel;
  logic [15:0]         priorityReg;
  logic [2:0]          avgLog;
  logic [31:0]         seqMux [NUM_SEQ];
  logic [31:0]         seqCtl [NUM_SEQ];

  logic                doneMeta;
  logic                doneSync;
  logic [NUM_EXT_TRG-1:0] trigMeta;
  logic [NUM_EXT_TRG-1:0] trigSync;
  logic [NUM_EXT_TRG-1:0] trigPrev;
  logic [NUM_EXT_TRG-1:0] trigEdge;

  seq_state_t          state;
  logic [1:0]          curSeq;
  logic [2:0]          step;
  logic [6:0]          avgCount;
  logic [ACC_W-1:0]    acc;
  logic [7:0]          divCount;

  logic [NUM_SEQ-1:0]  fifoPop;
  logic [NUM_SEQ-1:0]  fifoPush;
  logic [NUM_SEQ-1:0]  fifoFull;
  logic [NUM_SEQ-1:0]  fifoEmpty;
  logic [RESULT_W-1:0] popData [NUM_SEQ];
  logic [3:0]          headPtr [NUM_SEQ];
  logic [3:0]          tailPtr [NUM_SEQ];
  logic [NUM_SEQ-1:0]  seqWrMux;
  logic [NUM_SEQ-1:0]  seqWrCtl;
  logic [NUM_SEQ-1:0]  trigHit;
  logic [NUM_SEQ-1:0]  initiate;
  logic [3:0]          curCtl;
  logic                lastAvg;
  logic                lastStep;
  logic                pushNow;
  logic [RESULT_W-1:0] pushData;
  logic                anyPending;
  logic [1:0]          winner;
  logic [WORD_W-1:0]   next_regRdata;

  assign seqIrq = rawIrq & irqMask;

  // Converter core lives in its own clock; done is a level of a 4-phase handshake
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      doneMeta <= 1'b0;
      doneSync <= 1'b0;
      trigMeta <= '0;
      trigSync <= '0;
      trigPrev <= '0;
    end else begin
      doneMeta <= convDone;
      doneSync <= doneMeta;
      trigMeta <= extTrigger;
      trigSync <= trigMeta;
      trigPrev <= trigSync;
    end
  end
  assign trigEdge = trigSync & ~trigPrev;

  // Converter clock derived from the system clock with no software setting
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      divCount <= '0;
      convClk  <= 1'b0;
    end else begin
      divCount <= (divCount == 8'(CONV_DIV - 1)) ? '0 : divCount + 1'b1;
      convClk  <= (divCount < 8'(CONV_DIV / 2));
    end
  end

  // Register decode
  always_comb begin
    initiate = '0;
    for (int n = 0; n < NUM_SEQ; n++) begin
      seqWrMux[n] = regWrite && regAddr == 12'(OFF_SEQ_BASE + SEQ_STRIDE * n + SEQ_INPUT_SEL);
      seqWrCtl[n] = regWrite && regAddr == 12'(OFF_SEQ_BASE + SEQ_STRIDE * n + SEQ_SAMPLE_CTL);
      fifoPop[n]  = regRead && regAddr == 12'(OFF_SEQ_BASE + SEQ_STRIDE * n + SEQ_RESULT);
      if (regWrite && regAddr == OFF_INITIATE) begin
        initiate[n] = regWdata[n];
      end
    end
  end

  // Trigger selection per sequencer
  always_comb begin
    for (int n = 0; n < NUM_SEQ; n++) begin
      unique case (eventSel[4*n +: 4])
        EV_SOFTWARE: trigHit[n] = initiate[n];
        EV_TIMER:    trigHit[n] = trigEdge[0];
        EV_COMPARE:  trigHit[n] = trigEdge[1];
        EV_PWM:      trigHit[n] = trigEdge[2];
        EV_GPIO:     trigHit[n] = trigEdge[3];
        EV_ALWAYS:   trigHit[n] = 1'b1;
        default:     trigHit[n] = 1'b0;
      endcase
    end
  end

  // Priority arbiter; equal priorities fall back to lowest index
  always_comb begin
    logic [2:0] best;
    best       = 3'h4;
    winner     = 2'h0;
    anyPending = 1'b0;
    for (int n = NUM_SEQ - 1; n >= 0; n--) begin
      if (pending[n] && activeEnable[n] && {1'b0, priorityReg[4*n +: 2]} <= best) begin
        best       = {1'b0, priorityReg[4*n +: 2]};
        winner     = 2'(n);
        anyPending = 1'b1;
      end
    end
  end

  // Control registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      activeEnable <= '0;
      irqMask      <= '0;
      eventSel     <= '0;
      priorityReg  <= PRIORITY_RESET;
      avgLog       <= AVERAGE_RESET;
    end else if (regWrite) begin
      unique case (regAddr)
        OFF_ACTIVE:    activeEnable <= regWdata[NUM_SEQ-1:0];
        OFF_IRQ_MASK:  irqMask      <= regWdata[NUM_SEQ-1:0];
        OFF_EVENT_SEL: eventSel     <= regWdata[15:0];
        OFF_PRIORITY:  priorityReg  <= regWdata[15:0] & 16'h3333;
        OFF_AVERAGE:   avgLog       <= (regWdata[2:0] > AVERAGE_MAX) ? AVERAGE_MAX
                                                                     : regWdata[2:0];
        default:       ;
      endcase
    end
  end

  // Step tables stay writable whether or not the sequencer runs
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int n = 0; n < NUM_SEQ; n++) begin
        seqMux[n] <= '0;
        seqCtl[n] <= '0;
      end
    end else begin
      for (int n = 0; n < NUM_SEQ; n++) begin
        if (seqWrMux[n]) begin
          seqMux[n] <= regWdata & seqNibbleMask(n);
        end
        if (seqWrCtl[n]) begin
          seqCtl[n] <= regWdata & seqNibbleMask(n);
        end
      end
    end
  end

  // Sticky flags; a new event in the clear cycle wins
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rawIrq        <= '0;
      overflowFlag  <= '0;
      underflowFlag <= '0;
      pending       <= '0;
    end else begin
      for (int n = 0; n < NUM_SEQ; n++) begin
        if (fifoPush[n] && curCtl[CTL_IE]) begin
          rawIrq[n] <= 1'b1;
        end else if (regWrite && regAddr == OFF_IRQ_CLEAR && regWdata[n]) begin
          rawIrq[n] <= 1'b0;
        end
        if (fifoPush[n] && fifoFull[n]) begin
          overflowFlag[n] <= 1'b1;
        end else if (regWrite && regAddr == OFF_OVERFLOW && regWdata[n]) begin
          overflowFlag[n] <= 1'b0;
        end
        if (fifoPop[n] && fifoEmpty[n]) begin
          underflowFlag[n] <= 1'b1;
        end else if (regWrite && regAddr == OFF_UNDERFLOW && regWdata[n]) begin
          underflowFlag[n] <= 1'b0;
        end
        if (activeEnable[n] && trigHit[n]) begin
          pending[n] <= 1'b1;
        end else if (!activeEnable[n] || (state == ST_IDLE && anyPending && winner == 2'(n))) begin
          pending[n] <= 1'b0;
        end
      end
    end
  end

  // Sample engine
  assign lastAvg  = (avgCount == 7'((1 << avgLog) - 1));
  assign lastStep = curCtl[CTL_END] || step == 3'(seqDepth(int'(curSeq)) - 1);
  assign pushNow  = (state == ST_RELEASE) && !doneSync && lastAvg;
  assign pushData = RESULT_W'(acc >> avgLog);

  always_comb begin
    fifoPush = '0;
    fifoPush[curSeq] = pushNow;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state       <= ST_IDLE;
      curSeq      <= '0;
      step        <= '0;
      avgCount    <= '0;
      acc         <= '0;
      curCtl      <= '0;
      convStart   <= 1'b0;
      convInput   <= '0;
      convDiff    <= 1'b0;
      convTempSel <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (anyPending) begin
            curSeq      <= winner;
            step        <= '0;
            avgCount    <= '0;
            acc         <= '0;
            curCtl      <= seqCtl[winner][3:0];
            convInput   <= seqMux[winner][3:0];
            convDiff    <= seqCtl[winner][CTL_DIFF];
            convTempSel <= seqCtl[winner][CTL_TEMP];
            convStart   <= 1'b1;
            state       <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (doneSync) begin
            acc       <= acc + ACC_W'(convResult);
            convStart <= 1'b0;
            state     <= ST_RELEASE;
          end
        end
        ST_RELEASE: begin
          if (!doneSync) begin
            if (!lastAvg) begin
              avgCount  <= avgCount + 1'b1;
              convStart <= 1'b1;
              state     <= ST_CONV;
            end else if (lastStep || !activeEnable[curSeq]) begin
              state <= ST_IDLE;
            end else begin
              step        <= step + 1'b1;
              avgCount    <= '0;
              acc         <= '0;
              curCtl      <= seqCtl[curSeq][4*(step+1'b1) +: 4];
              convInput   <= seqMux[curSeq][4*(step+1'b1) +: 4];
              convDiff    <= seqCtl[curSeq][4*(step+1'b1) + CTL_DIFF];
              convTempSel <= seqCtl[curSeq][4*(step+1'b1) + CTL_TEMP];
              convStart   <= 1'b1;
              state       <= ST_CONV;
            end
          end
        end
      endcase
    end
  end

  generate
    for (genvar n = 0; n < NUM_SEQ; n++) begin : g_fifo
      seq_result_fifo #(
        .DEPTH (seqDepth(n)),
        .WIDTH (RESULT_W)
      ) u_fifo (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .pushValid (fifoPush[n]),
        .pushData  (pushData),
        .popReq    (fifoPop[n]),
        .popData   (popData[n]),
        .headPtr   (headPtr[n]),
        .tailPtr   (tailPtr[n]),
        .full      (fifoFull[n]),
        .empty     (fifoEmpty[n])
      );
    end
  endgenerate

  // Read data, one cycle after the strobe
  always_comb begin
    next_regRdata = '0;
    unique case (regAddr)
      OFF_ACTIVE:    next_regRdata[NUM_SEQ-1:0] = activeEnable;
      OFF_RAW_IRQ:   next_regRdata[NUM_SEQ-1:0] = rawIrq;
      OFF_IRQ_MASK:  next_regRdata[NUM_SEQ-1:0] = irqMask;
      OFF_IRQ_CLEAR: next_regRdata[NUM_SEQ-1:0] = seqIrq;
      OFF_OVERFLOW:  next_regRdata[NUM_SEQ-1:0] = overflowFlag;
      OFF_EVENT_SEL: next_regRdata[15:0] = eventSel;
      OFF_UNDERFLOW: next_regRdata[NUM_SEQ-1:0] = underflowFlag;
      OFF_PRIORITY:  next_regRdata[15:0] = priorityReg;
      OFF_AVERAGE:   next_regRdata[2:0] = avgLog;
      default:       ;
    endcase
    for (int n = 0; n < NUM_SEQ; n++) begin
      if (regAddr == 12'(OFF_SEQ_BASE + SEQ_STRIDE * n + SEQ_INPUT_SEL)) begin
        next_regRdata = seqMux[n];
      end
      if (regAddr == 12'(OFF_SEQ_BASE + SEQ_STRIDE * n + SEQ_SAMPLE_CTL)) begin
        next_regRdata = seqCtl[n];
      end
      if (regAddr == 12'(OFF_SEQ_BASE + SEQ_STRIDE * n + SEQ_RESULT) && !fifoEmpty[n]) begin
        next_regRdata[RESULT_W-1:0] = popData[n];
      end
      if (regAddr == 12'(OFF_SEQ_BASE + SEQ_STRIDE * n + SEQ_STATUS)) begin
        next_regRdata[STAT_TAIL_LSB +: 4] = tailPtr[n];
        next_regRdata[STAT_HEAD_LSB +: 4] = headPtr[n];
        next_regRdata[STAT_EMPTY]         = fifoEmpty[n];
        next_regRdata[STAT_FULL]          = fifoFull[n];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      regRdata <= '0;
    end else begin
      regRdata <= regRead ? next_regRdata : '0;
    end
  end

  // Checks
  sequence s_conv_taken;
    state == ST_CONV && doneSync;
  endsequence
  sequence s_released;
    !convStart && state == ST_RELEASE;
  endsequence

  property p_irq_mask;
    @(posedge clk_sys) disable iff (!reset_n)
    regRead && regAddr == OFF_IRQ_CLEAR |=>
      regRdata[NUM_SEQ-1:0] == ($past(rawIrq) & $past(irqMask));
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq missing");

  property p_irq_set;
    @(posedge clk_sys) disable iff (!reset_n)
    pushNow && curCtl[CTL_IE] |=> rawIrq[$past(curSeq)];
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("sample irq not raised");

  property p_overflow;
    @(posedge clk_sys) disable iff (!reset_n)
    pushNow && fifoFull[curSeq] |=> overflowFlag[$past(curSeq)];
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not flagged");

  property p_underflow;
    @(posedge clk_sys) disable iff (!reset_n)
    fifoPop[0] && fifoEmpty[0] |=> underflowFlag[0] && $stable(headPtr[0]);
  endproperty
  a_underflow: assert property (p_underflow) else $error("underflow wrong");

  property p_handshake;
    @(posedge clk_sys) disable iff (!reset_n)
    s_conv_taken |=> s_released;
  endproperty
  a_handshake: assert property (p_handshake) else $error("start not released");

  property p_idle_disabled;
    @(posedge clk_sys) disable iff (!reset_n)
    state == ST_IDLE && activeEnable == '0 |=> state == ST_IDLE;
  endproperty
  a_idle_disabled: assert property (p_idle_disabled) else $error("disabled seq ran");

  property p_end_stops;
    @(posedge clk_sys) disable iff (!reset_n)
    pushNow && curCtl[CTL_END] |=> state == ST_IDLE;
  endproperty
  a_end_stops: assert property (p_end_stops) else $error("ran past end");

  property p_next_step;
    @(posedge clk_sys) disable iff (!reset_n)
    pushNow && !lastStep && activeEnable[curSeq] |=>
      state == ST_CONV && convStart && step == $past(step) + 3'h1;
  endproperty
  a_next_step: assert property (p_next_step) else $error("no back to back step");

  property p_pop_data;
    @(posedge clk_sys) disable iff (!reset_n)
    fifoPop[0] && !fifoEmpty[0] |=> regRdata[RESULT_W-1:0] == $past(popData[0]);
  endproperty
  a_pop_data: assert property (p_pop_data) else $error("fifo read wrong");

  property p_passthrough;
    @(posedge clk_sys) disable iff (!reset_n)
    state == ST_CONV && doneSync && avgLog == 3'h0 && avgCount == 7'h0 |=>
      acc == ACC_W'($past(convResult));
  endproperty
  a_passthrough: assert property (p_passthrough) else $error("no passthrough");

endmodule : adc_sample_sequencer_control

/* verif/conv_core_model.sv */
`timescale 1ns/1ps
module conv_core_model (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       convStart,
  input  wire logic [3:0] convInput,
  input  wire logic       convDiff,
  input  wire logic       convTempSel,
  output logic            convDone,
  output logic      [9:0] convResult
);
  logic [2:0] waitCnt;
  logic       slow;

  // Alternate prompt and slow answers so the done path sees both
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      convDone   <= 1'b0;
      convResult <= 10'h3FF;
      waitCnt    <= 3'h0;
      slow       <= 1'b0;
    end else if (convStart && !convDone) begin
      waitCnt <= waitCnt + 3'h1;
      if (waitCnt == (slow ? 3'h5 : 3'h0)) begin
        convDone   <= 1'b1;
        convResult <= {2'b01, convTempSel, convDiff, 2'b00, convInput};
        slow       <= ~slow;
        waitCnt    <= 3'h0;
      end
    end else if (convDone && !convStart) begin
      convDone   <= 1'b0;
      // Released bus: never leave the old result readable
      convResult <= ~convResult;
    end
  end
endmodule : conv_core_model

/* verif/adc_sample_sequencer_control_bench.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module adc_sample_sequencer_control_bench;
  import adc_seq_pkg::*;
  logic        clk_sys, reset_n, regWrite, regRead, convDone;
  logic        convClk, convStart, convDiff, convTempSel;
  logic [11:0] regAddr;
  logic [31:0] regWdata, regRdata, d;
  logic [3:0]  extTrigger, convInput, seqIrq;
  logic [9:0]  convResult;
  logic [9:0]  expRes [5] = '{10'h101, 10'h102, 10'h141, 10'h183, 10'h100};
  int          mismatches, comparisons, cyc;
  int          highs;

  adc_sample_sequencer_control dut (.clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .extTrigger(extTrigger), .convClk(convClk), .convStart(convStart), .convInput(convInput),
    .convDiff(convDiff), .convTempSel(convTempSel), .convDone(convDone),
    .convResult(convResult), .seqIrq(seqIrq));
  conv_core_model core (.clk_sys(clk_sys), .reset_n(reset_n), .convStart(convStart),
    .convInput(convInput), .convDiff(convDiff), .convTempSel(convTempSel),
    .convDone(convDone), .convResult(convResult));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  function automatic logic [11:0] sa(input logic [1:0] n, input logic [11:0] o);
    sa = OFF_SEQ_BASE + SEQ_STRIDE * {10'h0, n} + o;
  endfunction : sa

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= v;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask : rd

  task automatic waitTail(input logic [1:0] n, input logic [3:0] t);
    for (int i = 0; i < 300; i++) begin
      rd(sa(n, SEQ_STATUS));
      if (d[3:0] === t) break;
    end
  endtask : waitTail

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  // Ceiling well above the few hundred cycles the tests need
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end

  initial begin
    reset_n = 1'b0;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 12'h000;
    regWdata = 32'h0;
    extTrigger = 4'h0;
    cyc = 0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(OFF_PRIORITY); `CHK("prio", 32'h3210, d)
    rd(sa(0, SEQ_STATUS)); `CHK("stat0", 32'h100, d)
    rd(OFF_AVERAGE); `CHK("avg", 32'h0, d)
    // Count high phases over two full divider periods
    highs = 0;
    repeat (2 * CONV_DIV) begin
      @(posedge clk_sys);
      #1 highs += int'(convClk);
    end
    `CHK("clkdiv", 2 * (CONV_DIV / 2), highs)
    // Five steps, repeated input, END on the fifth, a live sixth step behind it
    wr(sa(0, SEQ_INPUT_SEL), 32'h0020_3121);
    wr(sa(0, SEQ_SAMPLE_CTL), 32'h0006_8140);
    rd(sa(0, SEQ_INPUT_SEL)); `CHK("mux0", 32'h0020_3121, d)
    wr(OFF_INITIATE, 32'h1);
    repeat (40) @(posedge clk_sys);
    rd(sa(0, SEQ_STATUS)); `CHK("off", 32'h100, d)
    wr(OFF_IRQ_MASK, 32'h1);
    wr(OFF_ACTIVE, 32'h1);
    wr(OFF_INITIATE, 32'h1);
    waitTail(2'd0, 4'h5);
    repeat (40) @(posedge clk_sys);
    rd(sa(0, SEQ_STATUS)); `CHK("run0", 32'h005, d)
    rd(OFF_RAW_IRQ); `CHK("raw", 32'h1, d)
    `CHK("irq", 4'h1, seqIrq)
    for (int k = 0; k < 5; k++) begin
      rd(sa(0, SEQ_RESULT)); `CHK("res0", {22'h0, expRes[k]}, d)
    end
    rd(sa(0, SEQ_STATUS)); `CHK("drain", 32'h155, d)
    rd(sa(0, SEQ_RESULT)); `CHK("under", 32'h0, d)
    rd(sa(0, SEQ_STATUS)); `CHK("keep", 32'h155, d)
    rd(OFF_UNDERFLOW); `CHK("uflag", 32'h1, d)
    wr(OFF_UNDERFLOW, 32'h1);
    rd(OFF_UNDERFLOW); `CHK("uclr", 32'h0, d)
    wr(OFF_IRQ_CLEAR, 32'h1);
    rd(OFF_RAW_IRQ); `CHK("rawclr", 32'h0, d)
    `CHK("irqclr", 4'h0, seqIrq)
    // Depth one: second result must be dropped
    wr(sa(3, SEQ_INPUT_SEL), 32'h2);
    wr(sa(3, SEQ_SAMPLE_CTL), 32'h2);
    wr(OFF_ACTIVE, 32'h9);
    wr(OFF_INITIATE, 32'h8);
    repeat (40) @(posedge clk_sys);
    wr(sa(3, SEQ_INPUT_SEL), 32'h3);
    wr(OFF_INITIATE, 32'h8);
    repeat (40) @(posedge clk_sys);
    rd(sa(3, SEQ_STATUS)); `CHK("full3", 32'h1000, d)
    rd(OFF_OVERFLOW); `CHK("oflag", 32'h8, d)
    rd(sa(3, SEQ_RESULT)); `CHK("res3", 32'h102, d)
    wr(OFF_OVERFLOW, 32'h8);
    rd(OFF_OVERFLOW); `CHK("oclr", 32'h0, d)
    // Sequencer two outranks one when both start together
    wr(sa(1, SEQ_INPUT_SEL), 32'h1);
    wr(sa(1, SEQ_SAMPLE_CTL), 32'h2);
    wr(sa(2, SEQ_INPUT_SEL), 32'h3);
    wr(sa(2, SEQ_SAMPLE_CTL), 32'h2);
    wr(OFF_PRIORITY, 32'h3012);
    wr(OFF_ACTIVE, 32'h6);
    wr(OFF_INITIATE, 32'h6);
    for (int i = 0; i < 100 && convStart !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    `CHK("first", 4'h3, convInput)
    repeat (60) @(posedge clk_sys);
    rd(sa(1, SEQ_RESULT)); `CHK("res1", 32'h101, d)
    rd(sa(2, SEQ_RESULT)); `CHK("res2", 32'h103, d)
    // Averaging clamps at its ceiling; then a timer edge starts a two-sample average
    wr(OFF_AVERAGE, 32'h7);
    rd(OFF_AVERAGE); `CHK("avgmax", {29'h0, AVERAGE_MAX}, d)
    wr(OFF_AVERAGE, 32'h1);
    wr(OFF_EVENT_SEL, 32'h1000);
    wr(OFF_ACTIVE, 32'h8);
    extTrigger <= 4'h1;
    repeat (80) @(posedge clk_sys);
    rd(sa(3, SEQ_RESULT)); `CHK("avg3", 32'h103, d)
    report_and_stop();
  end
endmodule : adc_sample_sequencer_control_bench
